// File: hdl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

    // APB byte addresses of the registers
    localparam logic [7:0] ADDR_BASE_ENABLE = 8'ha8;
    localparam logic [7:0] ADDR_T2_ENABLE = 8'he8;
    localparam logic [7:0] ADDR_BASE_PRIO = 8'hb8;
    localparam logic [7:0] ADDR_T2_PRIO = 8'hf8;
    localparam logic [7:0] ADDR_POWER_CTRL = 8'h88;
    localparam logic [7:0] ADDR_STATUS = 8'h90;
    localparam logic [7:0] ADDR_EVT_STATUS = 8'h94;
    localparam logic [7:0] ADDR_EVT_CLEAR = 8'h98;
    localparam logic [7:0] ADDR_EVT_ENABLE = 8'h9c;

    // Reset values
    localparam logic [7:0] RST_BASE_ENABLE = 8'h00;
    localparam logic [7:0] RST_T2_ENABLE = 8'h00;
    localparam logic [7:0] RST_BASE_PRIO = 8'h00;
    localparam logic [7:0] RST_T2_PRIO = 8'h00;

    // Field positions
    localparam int GLOBAL_GATE_BIT = 7;
    localparam int IDLE_BIT = 0;
    localparam logic [7:0] BASE_PRIO_MASK = 8'h7f;

    // Source indices in vector-table order
    localparam int NSRC = 15;
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_TIMER0 = 4'h1;
    localparam logic [3:0] SRC_EXT1 = 4'h2;
    localparam logic [3:0] SRC_TIMER1 = 4'h3;
    localparam logic [3:0] SRC_UART = 4'h4;
    localparam logic [3:0] SRC_CAN = 4'h5;
    localparam logic [3:0] SRC_CAP0 = 4'h6;
    localparam logic [3:0] SRC_CAP1 = 4'h7;
    localparam logic [3:0] SRC_CAP2 = 4'h8;
    localparam logic [3:0] SRC_CAP3 = 4'h9;
    localparam logic [3:0] SRC_ADC = 4'ha;
    localparam logic [3:0] SRC_CMP0 = 4'hb;
    localparam logic [3:0] SRC_CMP1 = 4'hc;
    localparam logic [3:0] SRC_CMP2 = 4'hd;
    localparam logic [3:0] SRC_T2OVF = 4'he;

    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam int VECTOR_STEP_SHIFT = 3;

    // Event status bits
    localparam int EVT_TAKE = 0;
    localparam int EVT_IDLE_WAKE = 1;
    localparam int EVT_BLOCKED = 2;

    typedef enum logic [1:0] {
        LVL_NONE = 2'b00,
        LVL_LOW = 2'b01,
        LVL_HIGH = 2'b11
    } level_t;

endpackage : irq_ctrl_pkg

// File: hdl/irq_ctrl.sv
// How it works
// - Timer-2 enable bit 7 gates overflow
// - Timer-2 enable bits 6..4 gate comparators
// - Timer-2 enable bits 3..0 gate captures
// - Base priority bits per base source
// - Timer-2 priority bit 7 sets overflow level
// - Timer-2 priority bits set compare, capture levels
// - Each source has own vector, step eight
// - High priority request wins over low
// - Fixed order among equal priority requests
// - Low routine preempted only by high
// - High routine blocks all further interrupts
// - Enabled idle-active interrupt clears idle bit
// - Global gate bit 7 blocks every source request
// - Base enable bits per base source
module irq_ctrl (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Request sources, level high
    input wire logic ext0_req,
    input wire logic timer0_req,
    input wire logic ext1_req,
    input wire logic timer1_req,
    input wire logic uart_req,
    input wire logic can_req,
    input wire logic adc_req,
    input wire logic [3:0] t2_cap_req,
    input wire logic [2:0] t2_cmp_req,
    input wire logic t2_overflow_req,
    // Idle-active source mask, 1 when that source keeps running in idle
    input wire logic [14:0] idle_active_src,
    // CPU core
    input wire logic vector_take,
    input wire logic service_return,
    output logic irq_pending,
    output logic [15:0] irq_vector,
    output logic idle_mode,
    output logic irq
);

    logic [7:0] base_irq_enable_q;
    logic [7:0] timer2_irq_enable_q;
    logic [7:0] base_irq_priority_q;
    logic [7:0] timer2_irq_priority_q;
    logic [7:0] power_control_reg_q;
    logic [2:0] evt_status_q;
    logic [2:0] evt_enable_q;
    logic in_low_q;
    logic in_high_q;
    logic [14:0] src_req;
    logic [14:0] src_en;
    logic [14:0] src_prio;
    logic [14:0] active;
    logic [14:0] act_hi;
    logic [14:0] act_lo;
    logic found_d;
    logic [3:0] win_d;
    logic win_hi_d;
    logic allowed_d;
    logic blocked_d;
    logic wake_d;
    logic wr_en;
    logic rd_en;
    logic [31:0] rdata_d;
    logic [2:0] evt_set;
    logic take_ok;
    logic [15:0] vector_d;
    logic idle_wake;
    logic pc_wr;

    // Fixed service order among equal levels
    localparam logic [3:0] ORDER [15] = '{
        irq_ctrl_pkg::SRC_EXT0,
        irq_ctrl_pkg::SRC_CAN,
        irq_ctrl_pkg::SRC_ADC,
        irq_ctrl_pkg::SRC_TIMER0,
        irq_ctrl_pkg::SRC_CAP0,
        irq_ctrl_pkg::SRC_CMP0,
        irq_ctrl_pkg::SRC_EXT1,
        irq_ctrl_pkg::SRC_CAP1,
        irq_ctrl_pkg::SRC_CMP1,
        irq_ctrl_pkg::SRC_TIMER1,
        irq_ctrl_pkg::SRC_CAP2,
        irq_ctrl_pkg::SRC_CMP2,
        irq_ctrl_pkg::SRC_UART,
        irq_ctrl_pkg::SRC_CAP3,
        irq_ctrl_pkg::SRC_T2OVF
    };

    // Decode of one write strobe, shared by every register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    // Requests packed so that bit i belongs to vector i
    assign src_req = {t2_overflow_req,
                      t2_cmp_req[2],
                      t2_cmp_req[1],
                      t2_cmp_req[0],
                      adc_req,
                      t2_cap_req[3],
                      t2_cap_req[2],
                      t2_cap_req[1],
                      t2_cap_req[0],
                      can_req,
                      uart_req,
                      timer1_req,
                      ext1_req,
                      timer0_req,
                      ext0_req};

    // Per-source enable and level mapped into vector order
    assign src_en = {timer2_irq_enable_q[7],
                     timer2_irq_enable_q[6:4],
                     base_irq_enable_q[6],
                     timer2_irq_enable_q[3:0],
                     base_irq_enable_q[5:0]};
    assign src_prio = {timer2_irq_priority_q[7],
                       timer2_irq_priority_q[6:4],
                       base_irq_priority_q[6],
                       timer2_irq_priority_q[3:0],
                       base_irq_priority_q[5:0]};

    // Global gate wipes every request
    assign active = base_irq_enable_q[irq_ctrl_pkg::GLOBAL_GATE_BIT]
                    ? (src_req & src_en) : '0;
    assign act_hi = active & src_prio;
    assign act_lo = active & ~src_prio;

    always_comb begin
        found_d = 1'b0;
        win_d = 4'h0;
        win_hi_d = 1'b0;
        for (int i = 14; i >= 0; i--) begin
            if (act_lo[ORDER[i]]) begin
                found_d = 1'b1;
                win_d = ORDER[i];
            end
        end
        // High pass runs last so it overrides any low winner
        for (int i = 14; i >= 0; i--) begin
            if (act_hi[ORDER[i]]) begin
                found_d = 1'b1;
                win_d = ORDER[i];
                win_hi_d = 1'b1;
            end
        end
    end

    // Nesting: a high routine blocks all, a low routine lets only high through
    always_comb begin
        if (in_high_q) begin
            allowed_d = 1'b0;
        end else if (in_low_q) begin
            allowed_d = found_d && win_hi_d;
        end else begin
            allowed_d = found_d;
        end
        blocked_d = found_d && !allowed_d;
    end

    assign take_ok = vector_take && irq_pending;
    assign wake_d = |(active & idle_active_src);

    // Service entries sit eight bytes apart, upward from the base
    assign vector_d = irq_ctrl_pkg::VECTOR_BASE
                      + (16'(win_d) << irq_ctrl_pkg::VECTOR_STEP_SHIFT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pending <= 1'b0;
            irq_vector <= 16'h0000;
        end else begin
            irq_pending <= allowed_d && !take_ok;
            irq_vector <= vector_d;
        end
    end

    // Active-level tracking from the core handshake; a return closes the
    // innermost level, which is high whenever both are open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_low_q <= 1'b0;
            in_high_q <= 1'b0;
        end else if (take_ok) begin
            if (win_hi_d) begin
                in_high_q <= 1'b1;
            end else begin
                in_low_q <= 1'b1;
            end
        end else if (service_return) begin
            if (in_high_q) begin
                in_high_q <= 1'b0;
            end else begin
                in_low_q <= 1'b0;
            end
        end
    end

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pc_wr = wr_en && hit(paddr, irq_ctrl_pkg::ADDR_POWER_CTRL);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_irq_enable_q <= irq_ctrl_pkg::RST_BASE_ENABLE;
            timer2_irq_enable_q <= irq_ctrl_pkg::RST_T2_ENABLE;
            base_irq_priority_q <= irq_ctrl_pkg::RST_BASE_PRIO;
            timer2_irq_priority_q <= irq_ctrl_pkg::RST_T2_PRIO;
            evt_enable_q <= 3'h0;
        end else if (wr_en) begin
            if (hit(paddr, irq_ctrl_pkg::ADDR_BASE_ENABLE)) begin
                base_irq_enable_q <= pwdata[7:0];
            end
            if (hit(paddr, irq_ctrl_pkg::ADDR_T2_ENABLE)) begin
                timer2_irq_enable_q <= pwdata[7:0];
            end
            if (hit(paddr, irq_ctrl_pkg::ADDR_BASE_PRIO)) begin
                base_irq_priority_q <= pwdata[7:0] & irq_ctrl_pkg::BASE_PRIO_MASK;
            end
            if (hit(paddr, irq_ctrl_pkg::ADDR_T2_PRIO)) begin
                timer2_irq_priority_q <= pwdata[7:0];
            end
            if (hit(paddr, irq_ctrl_pkg::ADDR_EVT_ENABLE)) begin
                evt_enable_q <= pwdata[2:0];
            end
        end
    end

    // Idle bit: hardware clear wins over a same-cycle software write, so a
    // wake request can never be swallowed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_control_reg_q <= 8'h00;
        end else begin
            if (pc_wr) begin
                power_control_reg_q <= pwdata[7:0];
            end
            if (wake_d && (power_control_reg_q[irq_ctrl_pkg::IDLE_BIT] || pc_wr)) begin
                power_control_reg_q[irq_ctrl_pkg::IDLE_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_mode <= 1'b0;
        end else begin
            idle_mode <= power_control_reg_q[irq_ctrl_pkg::IDLE_BIT] && !wake_d;
        end
    end

    // Sticky events; set wins over clear, so an event in the clear cycle is kept
    assign idle_wake = wake_d && power_control_reg_q[irq_ctrl_pkg::IDLE_BIT];

    always_comb begin
        evt_set = 3'h0;
        evt_set[irq_ctrl_pkg::EVT_TAKE] = take_ok;
        evt_set[irq_ctrl_pkg::EVT_IDLE_WAKE] = idle_wake;
        evt_set[irq_ctrl_pkg::EVT_BLOCKED] = blocked_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status_q <= 3'h0;
        end else begin
            if (wr_en && hit(paddr, irq_ctrl_pkg::ADDR_EVT_CLEAR)) begin
                evt_status_q <= (evt_status_q & ~pwdata[2:0]) | evt_set;
            end else begin
                evt_status_q <= evt_status_q | evt_set;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_status_q & evt_enable_q);
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (paddr)
            irq_ctrl_pkg::ADDR_BASE_ENABLE: rdata_d[7:0] = base_irq_enable_q;
            irq_ctrl_pkg::ADDR_T2_ENABLE: rdata_d[7:0] = timer2_irq_enable_q;
            irq_ctrl_pkg::ADDR_BASE_PRIO: rdata_d[7:0] = base_irq_priority_q;
            irq_ctrl_pkg::ADDR_T2_PRIO: rdata_d[7:0] = timer2_irq_priority_q;
            irq_ctrl_pkg::ADDR_POWER_CTRL: rdata_d[7:0] = power_control_reg_q;
            irq_ctrl_pkg::ADDR_STATUS: rdata_d[7:0] = {in_high_q, in_low_q, win_hi_d, win_d, found_d};
            irq_ctrl_pkg::ADDR_EVT_STATUS: rdata_d[2:0] = evt_status_q;
            irq_ctrl_pkg::ADDR_EVT_ENABLE: rdata_d[2:0] = evt_enable_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Fixed zero-wait-state slave: data is captured in setup, ready in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (rd_en) begin
                prdata <= rdata_d;
            end
            pready <= psel && !penable;
            pslverr <= 1'b0;
        end
    end

endmodule : irq_ctrl

// File: verification/irq_ctrl_asserts.sv
module irq_ctrl_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Core
    input wire logic vector_take,
    input wire logic service_return,
    input wire logic irq_pending,
    input wire logic [15:0] irq_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    logic gate_q;
    logic [1:0] depth_q;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Mirror of the global gate, same edge as the register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q <= 1'b0;
        end else if (psel && penable && pwrite && paddr == irq_ctrl_pkg::ADDR_BASE_ENABLE) begin
            gate_q <= pwdata[irq_ctrl_pkg::GLOBAL_GATE_BIT];
        end
    end
    // Open routines; only low then high can reach two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_q <= 2'h0;
        end else begin
            depth_q <= depth_q + 2'(vector_take && irq_pending)
                - 2'(service_return && depth_q != 2'h0);
        end
    end
    a_vector_table: assert property (irq_pending |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0073)
        else $error("vector outside table");
    a_gate_blocks: assert property (!gate_q && !$past(gate_q) |-> !irq_pending)
        else $error("pending with gate off");
    a_take_clears: assert property (vector_take && irq_pending |=> !irq_pending)
        else $error("pending after take");
    a_high_blocks: assert property (depth_q == 2'h2 |-> !irq_pending)
        else $error("pending inside high routine");
    a_depth_bound: assert property (depth_q != 2'h3)
        else $error("third nesting level");
    a_ready_access: assert property (pready == (psel && penable))
        else $error("pready outside access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_no_error: assert property (!pslverr)
        else $error("slave error");
    c_take: cover property (vector_take && irq_pending);
    c_nested: cover property (depth_q == 2'h2);
    c_return: cover property (service_return ##1 irq_pending);
endmodule : irq_ctrl_asserts

bind irq_ctrl irq_ctrl_asserts irq_ctrl_asserts_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .vector_take, .service_return,
    .irq_pending, .irq_vector);

// File: verification/core_model.sv
module core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Controller
    input wire logic irq_pending,
    input wire logic [15:0] irq_vector,
    output logic vector_take,
    output logic service_return,
    // Bench
    input wire logic accept,
    output logic [15:0] last_vector,
    output int takes
);
    timeunit 1ns;
    timeprecision 1ps;
    initial service_return = 1'b0;
    // Never two takes in a row, so pending has time to fall
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_take <= 1'b0;
            last_vector <= 16'h0000;
            takes <= 0;
        end else begin
            vector_take <= irq_pending && accept && !vector_take;
            if (vector_take && irq_pending) begin
                last_vector <= irq_vector;
                takes <= takes + 1;
            end
        end
    end
    task automatic finish_routine();
        @(posedge pclk);
        service_return <= 1'b1;
        @(posedge pclk);
        service_return <= 1'b0;
    endtask : finish_routine
endmodule : core_model

// File: verification/irq_ctrl_tb.sv
module irq_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic [14:0] req = 15'h0;
    logic [14:0] idle_src = 15'h0;
    logic accept = 1'b1;
    logic pready, vector_take, service_return, irq_pending, idle_mode, irq;
    logic [15:0] irq_vector, last_vector;
    int takes, miscompares = 0, checks = 0;
    int order[15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};
    logic [7:0] regs[4] = '{irq_ctrl_pkg::ADDR_BASE_ENABLE, irq_ctrl_pkg::ADDR_T2_ENABLE,
        irq_ctrl_pkg::ADDR_BASE_PRIO, irq_ctrl_pkg::ADDR_T2_PRIO};
    always #2 pclk = ~pclk;
    irq_ctrl irq_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr(), .ext0_req(req[0]), .timer0_req(req[1]),
        .ext1_req(req[2]), .timer1_req(req[3]), .uart_req(req[4]), .can_req(req[5]),
        .adc_req(req[10]), .t2_cap_req(req[9:6]), .t2_cmp_req(req[13:11]),
        .t2_overflow_req(req[14]), .idle_active_src(idle_src), .vector_take,
        .service_return, .irq_pending, .irq_vector, .idle_mode, .irq);
    core_model core_model_inst (.pclk, .presetn, .irq_pending, .irq_vector, .vector_take,
        .service_return, .accept, .last_vector, .takes);
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    task automatic hang(string what);
        check(what, 0, 1);
        close_out();
    endtask : hang
    // Starts one edge after the last release, so no signal is set twice at once
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang("pready");
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rc(string what, logic [7:0] a, logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : rc
    task automatic wt(int i);
        int n0 = takes;
        int n = 0;
        while (takes == n0 && n < 60) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 60) hang("take");
        check("vector", last_vector, 16'h0003 + 16'(8 * i));
    endtask : wt
    // Register bits {timer-2, base} of source i, vector order
    function automatic logic [15:0] bit_of(int i);
        if (i < 6) return 16'h0001 << i;
        if (i == 10) return 16'h0040;
        if (i < 10) return 16'h0100 << (i - 6);
        if (i < 14) return 16'h1000 << (i - 11);
        return 16'h8000;
    endfunction : bit_of
    task automatic setup(logic [15:0] en, logic [15:0] pr);
        wr(irq_ctrl_pkg::ADDR_BASE_ENABLE, {24'h0, 1'b1, en[6:0]});
        wr(irq_ctrl_pkg::ADDR_T2_ENABLE, {24'h0, en[15:8]});
        wr(irq_ctrl_pkg::ADDR_BASE_PRIO, {24'h0, pr[7:0]});
        wr(irq_ctrl_pkg::ADDR_T2_PRIO, {24'h0, pr[15:8]});
    endtask : setup
    initial begin
        #200000;
        hang("run");
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[k]) begin
            rc("reset", regs[k], 0);
            wr(regs[k], 32'hffffffff);
            rc("store", regs[k], k == 2 ? 32'h7f : 32'hff);
        end
        rc("unmapped", 8'h04, 0);
        $display("registers done");
        req <= 15'h7fff;
        // Lone enable picks the source; lone high level beats lower order
        for (int i = 0; i < 15; i++) begin
            accept <= 1'b0;
            setup(bit_of(i), 16'h0);
            accept <= 1'b1;
            wt(i);
            core_model_inst.finish_routine();
            accept <= 1'b0;
            setup(16'hffff, bit_of(i));
            accept <= 1'b1;
            wt(i);
            core_model_inst.finish_routine();
        end
        accept <= 1'b0;
        setup(16'hffff, 16'h0);
        accept <= 1'b1;
        for (int i = 0; i < 15; i++) begin
            wt(order[i]);
            req[order[i]] <= 1'b0;
            core_model_inst.finish_routine();
        end
        $display("order done");
        setup(16'hffff, 16'hc000);
        req[0] <= 1'b1;
        wt(0);
        req[1] <= 1'b1;
        repeat (10) @(posedge pclk);
        check("low waits", irq_pending, 0);
        req[14] <= 1'b1;
        wt(14);
        rc("status nest", irq_ctrl_pkg::ADDR_STATUS, 32'hfd);
        req[13] <= 1'b1;
        repeat (10) @(posedge pclk);
        check("high blocks", irq_pending, 0);
        core_model_inst.finish_routine();
        wt(13);
        req <= 15'h0;
        core_model_inst.finish_routine();
        core_model_inst.finish_routine();
        wr(irq_ctrl_pkg::ADDR_BASE_ENABLE, 32'h7f);
        req <= 15'h7fff;
        repeat (10) @(posedge pclk);
        check("gate off", irq_pending, 0);
        $display("nesting done");
        accept <= 1'b0;
        req <= 15'h0002;
        idle_src <= 15'h0001;
        wr(irq_ctrl_pkg::ADDR_BASE_ENABLE, 32'hff);
        wr(irq_ctrl_pkg::ADDR_POWER_CTRL, 32'h1);
        rc("idle held", irq_ctrl_pkg::ADDR_POWER_CTRL, 1);
        check("idle mode", idle_mode, 1);
        req[0] <= 1'b1;
        repeat (4) @(posedge pclk);
        rc("idle woken", irq_ctrl_pkg::ADDR_POWER_CTRL, 0);
        check("idle left", idle_mode, 0);
        $display("idle done");
        req <= 15'h0;
        wr(irq_ctrl_pkg::ADDR_EVT_ENABLE, 0);
        wr(irq_ctrl_pkg::ADDR_EVT_CLEAR, 32'h7);
        accept <= 1'b1;
        rc("no events", irq_ctrl_pkg::ADDR_EVT_STATUS, 0);
        req[0] <= 1'b1;
        wt(0);
        req[0] <= 1'b0;
        core_model_inst.finish_routine();
        // The request still stands one edge into its routine, so it is also blocked
        rc("take event", irq_ctrl_pkg::ADDR_EVT_STATUS, 32'h5);
        check("irq masked", irq, 0);
        wr(irq_ctrl_pkg::ADDR_EVT_ENABLE, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq up", irq, 1);
        wr(irq_ctrl_pkg::ADDR_EVT_CLEAR, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq down", irq, 0);
        $display("events done");
        close_out();
    end
endmodule : irq_ctrl_tb
